// *** verilog/tvr_readout.sv ***
// Readout, status flags, scaling and AXI4-Lite registers of the readout block
//
// Function
// R1: Temperature counts are signed tenths of a degree.
// R2: Thermocouple and bipolar ranges always report 16-bit counts, bipolar signed.
// R3: Unipolar gives 0..32767 at 15 bit, 0..65535 at 16 bit.
// R4: Status occupies 24 bits, three aligned bytes in one status word.
// R5: Byte 0: bit0 self-test fail, bit1 supply missing, bit2 config not valid.
// R6: Byte 1 holds out-of-range flags, channel 1 in bit 0.
// R7: Byte 2 holds burn-out flags, channel 1 in bit 0.
// R8: Config-not-valid set until configured and after any unconfirmed change.
// R9: Self-test flag set while internal self-test has not passed.
// R10: Supply flag set while external 24 V supply is absent.
// R11: Burn-out mode forces count low, high, or disables open detection.
// R12: Active channel count configurable, all eight by default.
// R13: Global choice of Celsius or Fahrenheit counts.
// R14: Out-of-range flag set while input outside selected range.
// R15: Burn-out flag set while loop open and detection enabled.
// R16: Optional linear scaling from raw min/max onto engineering min/max.
// R17: Optional clamping of scaled value to engineering min/max.
// R18: Host checks config-not-valid clear before using readings.
// R19: Unused bits of the module status byte read zero.
`timescale 1ns/1ps
`default_nettype none
`include "tvr_consts.svh"
module tvr_readout import tvr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tvr_conv_s conv,
  input wire logic self_test_ok,
  input wire logic supply_present,
  output logic [3:0] fe_chan_count,
  output logic [31:0] fe_range,
  output logic fe_open_detect_en,
  output logic irq
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [`TVR_CTRL_W-1:0] ctrl_r;
  logic [31:0] range_r;
  logic [7:0] res16_r;
  logic stale_r;
  logic [23:0] irq_stat_r, irq_mask_r, stat_prev_r;
  logic [7:0] oor_r, burn_r;
  logic [15:0] raw_r [`TVR_NCH];
  logic [15:0] scl_r [`TVR_NCH];
  logic [31:0] rlim_r [`TVR_NCH];
  logic [31:0] elim_r [`TVR_NCH];
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_hold_r, w_hold_r;

  function automatic logic [31:0] tvr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : tvr_merge

  // ---------------------------------------------------------------
  // Write channel handshake
  // ---------------------------------------------------------------
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_hold_nxt = wr_go ? 1'b0 : (aw_hold_r | aw_take);
  wire w_hold_nxt = wr_go ? 1'b0 : (w_hold_r | w_take);
  wire bvalid_nxt = wr_go | (s_axi_bvalid & ~s_axi_bready);
  wire [2:0] wgrp = `TVR_GRP(aw_addr_r);
  wire [2:0] widx = `TVR_IDX(aw_addr_r);
  wire wbase = wr_go & (wgrp == `TVR_G_BASE);
  wire we_ctrl = wbase & (widx == `TVR_I_CTRL);
  wire we_range = wbase & (widx == `TVR_I_RANGE);
  wire we_res16 = wbase & (widx == `TVR_I_RES16);
  wire we_commit = wbase & (widx == `TVR_I_COMMIT);
  wire we_mask = wbase & (widx == `TVR_I_IRQMSK);
  wire we_rlim = wr_go & (wgrp == `TVR_G_RLIM);
  wire we_elim = wr_go & (wgrp == `TVR_G_ELIM);
  wire we_ro = wbase & ((widx == `TVR_I_STAT) | (widx == `TVR_I_IRQST));
  wire we_rogrp = wr_go & ((wgrp == `TVR_G_RAW) | (wgrp == `TVR_G_SCL));
  wire wr_mapped = we_ctrl | we_range | we_res16 | we_commit | we_mask | we_rlim | we_elim | we_ro | we_rogrp;
  wire [31:0] ctrl_m = tvr_merge({{(32-`TVR_CTRL_W){1'b0}}, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] res_m = tvr_merge({24'h000000, res16_r}, w_data_r, w_strb_r);

  // Hold flags remember a beat that is taken but not yet applied
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
    end
  end

  // Address and data may come in either order; each is latched on its own handshake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_addr_r <= 8'h00;
    end else if (aw_take) begin
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // Readies stay low while a beat is held or the response waits: one write in flight
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TVR_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_go) s_axi_bresp <= wr_mapped ? `TVR_RESP_OKAY : `TVR_RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Any change except to the interrupt mask leaves the device out of step until software confirms it
  wire cfg_write = we_ctrl | we_range | we_res16 | we_rlim | we_elim;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `TVR_CTRL_RST; // see R12
      range_r <= `TVR_RANGE_RST;
      res16_r <= `TVR_RES16_RST;
    end else begin
      if (we_ctrl) ctrl_r <= ctrl_m[`TVR_CTRL_W-1:0];
      if (we_range) range_r <= tvr_merge(range_r, w_data_r, w_strb_r);
      if (we_res16) res16_r <= res_m[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_mask_r <= 24'h000000;
    end else if (we_mask) begin
      irq_mask_r <= 24'(tvr_merge({8'h00, irq_mask_r}, w_data_r, w_strb_r));
    end
  end

  // A commit and a change never meet in one cycle: only one write is applied at a time
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stale_r <= 1'b1; // see R8
    end else if (we_commit) begin
      stale_r <= 1'b0; // see R8
    end else if (cfg_write) begin
      stale_r <= 1'b1; // see R8
    end
  end

  // Registered so the front-end pin comes straight from a flop, one cycle after the write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fe_open_detect_en <= 1'b0;
    end else begin
      fe_open_detect_en <= ctrl_r[`TVR_CTRL_BURN] != `TVR_BURN_OFF; // see R11
    end
  end

  assign fe_chan_count = ctrl_r[`TVR_CTRL_CNT];
  assign fe_range = range_r;

  // ---------------------------------------------------------------
  // Conversion to raw count
  // ---------------------------------------------------------------
  wire [3:0] cur_rg = range_r[{conv.chan, 2'b00} +: 4];
  wire cur_uni = (cur_rg == `TVR_RG_UNI39) | (cur_rg == `TVR_RG_UNI156) | (cur_rg == `TVR_RG_UNI125);
  wire tvr_kind_e cur_kind = (cur_rg <= `TVR_RG_TC_LAST) ? TVR_K_TEMP : (cur_uni ? TVR_K_UNI : TVR_K_BI);
  // Only unipolar ranges honour the 16-bit choice
  wire uni16 = (cur_kind == TVR_K_UNI) & res16_r[conv.chan]; // see R2
  wire [1:0] burn_mode = ctrl_r[`TVR_CTRL_BURN];
  wire open_hit = conv.open & (burn_mode != `TVR_BURN_OFF); // see R11, R15
  wire chan_on = {1'b0, conv.chan} < ctrl_r[`TVR_CTRL_CNT]; // see R12
  // Front end delivers tenths of a degree Celsius
  wire signed [20:0] c_ext = 21'($signed(conv.data));
  wire signed [20:0] f10 = c_ext * `TVR_F_MUL / `TVR_F_DIV + `TVR_F_OFS; // see R1, R13
  wire [15:0] temp_cnt = ctrl_r[`TVR_CTRL_FAHR] ? f10[15:0] : conv.data; // see R13
  wire [15:0] meas = (cur_kind == TVR_K_TEMP) ? temp_cnt :
                     ((cur_kind == TVR_K_UNI) & ~uni16) ? {1'b0, conv.data[15:1]} : conv.data; // see R3
  wire [15:0] force_lo = (cur_kind == TVR_K_UNI) ? `TVR_FORCE_ULO : `TVR_FORCE_SLO;
  wire [15:0] force_hi = uni16 ? `TVR_FORCE_UHI : `TVR_FORCE_SHI;
  wire [15:0] raw_nxt = !open_hit ? meas : ((burn_mode == `TVR_BURN_LOW) ? force_lo : force_hi); // see R11

  // ---------------------------------------------------------------
  // Linear scaling and clamping
  // ---------------------------------------------------------------
  // Unipolar counts are unsigned; everything else is two's complement
  wire signed [16:0] raw17 = (cur_kind == TVR_K_UNI) ? {1'b0, raw_nxt} : {raw_nxt[15], raw_nxt};
  wire [31:0] rl = rlim_r[conv.chan];
  wire [31:0] el = elim_r[conv.chan];
  wire signed [35:0] rmin = 36'($signed(rl[15:0]));
  wire signed [35:0] rmax = 36'($signed(rl[31:16]));
  wire signed [35:0] emin = 36'($signed(el[15:0]));
  wire signed [35:0] emax = 36'($signed(el[31:16]));
  wire signed [35:0] d_in = 36'(raw17) - rmin;
  wire signed [35:0] span_r = rmax - rmin;
  wire signed [35:0] span_e = emax - emin;
  wire signed [35:0] prod = d_in * span_e;
  // A zero raw span would divide by zero; it pins the result to the minimum
  wire signed [35:0] quot = (span_r == 36'sh0) ? 36'sh0 : prod / span_r; // see R16
  wire signed [35:0] scaled = emin + quot; // see R16
  wire do_clamp = ctrl_r[`TVR_CTRL_CLAMP];
  wire signed [35:0] clamped = !do_clamp ? scaled : (scaled < emin) ? emin :
                               (scaled > emax) ? emax : scaled; // see R17
  wire [15:0] scl_nxt = ctrl_r[`TVR_CTRL_SCALE] ? clamped[15:0] : raw_nxt;

  // ---------------------------------------------------------------
  // Per-channel words and flags
  // ---------------------------------------------------------------
  wire [2:0] lidx = `TVR_IDX(aw_addr_r);
  genvar ch;
  generate
    for (ch = 0; ch < `TVR_NCH; ch++) begin : g_ch
      wire hit = conv.valid & (conv.chan == 3'(ch)) & chan_on;
      wire off = 4'(ch) >= ctrl_r[`TVR_CTRL_CNT];
      wire rlim_we = we_rlim & (lidx == 3'(ch));
      wire elim_we = we_elim & (lidx == 3'(ch));
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          rlim_r[ch] <= `TVR_LIM_RST;
          elim_r[ch] <= `TVR_LIM_RST;
        end else begin
          if (rlim_we) rlim_r[ch] <= tvr_merge(rlim_r[ch], w_data_r, w_strb_r);
          if (elim_we) elim_r[ch] <= tvr_merge(elim_r[ch], w_data_r, w_strb_r);
        end
      end

      // Words of a channel that is switched off keep their last reading
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          raw_r[ch] <= 16'h0000;
          scl_r[ch] <= 16'h0000;
        end else if (hit) begin
          raw_r[ch] <= raw_nxt;
          scl_r[ch] <= scl_nxt;
        end
      end

      // Flags of an inactive channel are held clear so stale faults do not linger
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          oor_r[ch] <= 1'b0;
          burn_r[ch] <= 1'b0;
        end else if (off) begin
          oor_r[ch] <= 1'b0;
          burn_r[ch] <= 1'b0;
        end else if (hit) begin
          oor_r[ch] <= conv.over; // see R14
          burn_r[ch] <= open_hit; // see R15
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  wire [7:0] mod_stat = {`TVR_MOD_PAD, stale_r, ~supply_present, ~self_test_ok}; // see R5, R8, R9, R10, R19
  wire [23:0] stat_live = {burn_r, oor_r, mod_stat}; // see R4, R6, R7
  wire [23:0] ev = stat_live & ~stat_prev_r;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_clr = ar_take & (`TVR_GRP(s_axi_araddr) == `TVR_G_BASE) & (`TVR_IDX(s_axi_araddr) == `TVR_I_IRQST);
  // A new event in the clearing cycle survives the clear
  wire [23:0] irq_stat_nxt = (rd_clr ? 24'h000000 : irq_stat_r) | ev;

  // Last cycle's snapshot turns the level flags into rising-edge events
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_prev_r <= 24'h000000;
    end else begin
      stat_prev_r <= stat_live;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_stat_r <= 24'h000000;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Taken from the next state so the pin never lags the sticky bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [2:0] rgrp = `TVR_GRP(s_axi_araddr);
  wire [2:0] ridx = `TVR_IDX(s_axi_araddr);
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rgrp == `TVR_G_RAW) rd_val = {16'h0000, raw_r[ridx]};
    else if (rgrp == `TVR_G_SCL) rd_val = {16'h0000, scl_r[ridx]};
    else if (rgrp == `TVR_G_RLIM) rd_val = rlim_r[ridx];
    else if (rgrp == `TVR_G_ELIM) rd_val = elim_r[ridx];
    else if (rgrp != `TVR_G_BASE) rd_ok = 1'b0;
    else if (ridx == `TVR_I_CTRL) rd_val = {{(32-`TVR_CTRL_W){1'b0}}, ctrl_r};
    else if (ridx == `TVR_I_RANGE) rd_val = range_r;
    else if (ridx == `TVR_I_RES16) rd_val = {24'h000000, res16_r};
    else if (ridx == `TVR_I_STAT) rd_val = {8'h00, stat_live};
    else if (ridx == `TVR_I_IRQST) rd_val = {8'h00, irq_stat_r};
    else if (ridx == `TVR_I_IRQMSK) rd_val = {8'h00, irq_mask_r};
    else if (ridx != `TVR_I_COMMIT) rd_ok = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
    end
  end

  // Read data is captured when the address is taken and stands until rready
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TVR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `TVR_RESP_OKAY : `TVR_RESP_SLVERR;
    end
  end
endmodule : tvr_readout
`default_nettype wire

// *** shared/tvr_consts.svh ***
// Constants of the thermocouple/millivolt readout block
`ifndef TVR_CONSTS_SVH
`define TVR_CONSTS_SVH
`define TVR_NCH 8
// Register groups (address bits 7:5) and word index (bits 4:2)
`define TVR_GRP(a) a[7:5]
`define TVR_IDX(a) a[4:2]
`define TVR_G_BASE 3'h0
`define TVR_G_RAW 3'h1
`define TVR_G_SCL 3'h2
`define TVR_G_RLIM 3'h3
`define TVR_G_ELIM 3'h4
`define TVR_I_CTRL 3'h0
`define TVR_I_RANGE 3'h1
`define TVR_I_RES16 3'h2
`define TVR_I_COMMIT 3'h3
`define TVR_I_STAT 3'h4
`define TVR_I_IRQST 3'h5
`define TVR_I_IRQMSK 3'h6
// Control word fields
`define TVR_CTRL_W 9
`define TVR_CTRL_CNT 3:0
`define TVR_CTRL_FAHR 4
`define TVR_CTRL_BURN 6:5
`define TVR_CTRL_CLAMP 7
`define TVR_CTRL_SCALE 8
`define TVR_CTRL_RST 9'h008
`define TVR_RANGE_RST 32'h0000_0000
`define TVR_RES16_RST 8'h00
`define TVR_LIM_RST 32'h7fff_0000
// Burn-out modes
`define TVR_BURN_LOW 2'h0
`define TVR_BURN_HIGH 2'h1
`define TVR_BURN_OFF 2'h2
// Range codes 0..8 are thermocouple types
`define TVR_RG_TC_LAST 4'h8
`define TVR_RG_UNI39 4'h9
`define TVR_RG_UNI156 4'hc
`define TVR_RG_UNI125 4'he
// Forced counts on an open input
`define TVR_FORCE_SLO 16'h8000
`define TVR_FORCE_ULO 16'h0000
`define TVR_FORCE_SHI 16'h7fff
`define TVR_FORCE_UHI 16'hffff
// Tenths of a degree: F = C*9/5 + 32.0
`define TVR_F_MUL 21'sh00009
`define TVR_F_DIV 21'sh00005
`define TVR_F_OFS 21'sh00140
`define TVR_MOD_PAD 5'h00
`define TVR_RESP_OKAY 2'h0
`define TVR_RESP_SLVERR 2'h2
`endif

// *** shared/tvr_pkg.sv ***
// Types of the thermocouple/millivolt readout block
package tvr_pkg;
  typedef enum logic [1:0] {TVR_K_TEMP, TVR_K_UNI, TVR_K_BI} tvr_kind_e;
  // One finished conversion from the analog front end
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [15:0] data;
    logic open;
    logic over;
  } tvr_conv_s;
endpackage : tvr_pkg

// *** dv/tvr_readout_assertions.sv ***
// Port-level checker of the readout block
`timescale 1ns/1ps
`default_nettype none
module tvr_readout_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] fe_chan_count,
  input wire logic [31:0] fe_range,
  input wire logic fe_open_detect_en,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] rd_addr_r;
  // Remember which word the pending read answer belongs to
  always_ff @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_r <= s_axi_araddr;
    end
  end
  a_rst_values: assert property ($rose(rst_n) |-> fe_chan_count == 4'h8 && fe_range == 32'h0 && !irq)
    else $error("bad values after reset");
  a_detect_on: assert property ($rose(rst_n) |-> ##[1:3] fe_open_detect_en)
    else $error("open detection not enabled by default");
  a_stat_pad: assert property (s_axi_rvalid && rd_addr_r == 8'h10 |-> s_axi_rdata[7:3] == 5'h0 && s_axi_rdata[31:24] == 8'h0)
    else $error("status padding not zero");
  a_unmapped_err: assert property (s_axi_rvalid && rd_addr_r > 8'h9f |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_detect_off: cover property ($fell(fe_open_detect_en));
endmodule : tvr_readout_assertions
`default_nettype wire

// *** dv/tvr_host_model.sv ***
// Host side model: AXI4-Lite master reaching the readout registers
`timescale 1ns/1ps
`default_nettype none
module tvr_host_model (
  input wire logic sys_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  // Responses are always accepted at once, so only valid is waited for
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    dt = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd
  // A reading taken while the configuration is stale is poisoned
  task automatic rdv(input logic [7:0] a, output logic [31:0] dt);
    logic [31:0] st;
    logic [1:0] rs;
    rd(8'h10, st, rs);
    rd(a, dt, rs);
    if (st[2]) dt = 32'hffff_ffff;
  endtask : rdv
endmodule : tvr_host_model
`default_nettype wire

// *** dv/tvr_readout_tb_top.sv ***
// Self-checking testbench of the readout block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, ex, gt) chk(n, 32'(ex), 32'(gt))
module tvr_readout_tb_top import tvr_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic self_test_ok = 1'b1;
  logic supply_present = 1'b1;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  tvr_conv_s conv = '0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, irq, fe_open_detect_en, fh, op, ov;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fe_range, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, m;
  logic [3:0] fe_chan_count;
  logic [15:0] v, e;
  logic [3:0] rg [4] = '{4'h0, 4'h9, 4'ha, 4'hc};
  logic [15:0] last [4];
  int sv [4] = '{500, 2000, 2000, -300};
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 79693;
  tvr_readout DUT (.*);
  tvr_host_model H (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [31:0] ex, logic [31:0] gt);
    compares++;
    if (gt !== ex) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, gt);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] exp_raw(logic [3:0] g, logic r16, logic f, logic [1:0] bm, logic o, logic [15:0] x);
    logic u;
    u = g == 4'h9 || g == 4'hc || g == 4'he;
    if (o && bm != 2'h2) return bm == 2'h0 ? (u ? 16'h0 : 16'h8000) : (u && r16 ? 16'hffff : 16'h7fff);
    if (g <= 4'h8) return f ? 16'(($signed(x) * 9) / 5 + 320) : x;
    if (u) return r16 ? x : {1'b0, x[15:1]};
    return x;
  endfunction : exp_raw
  function automatic logic [15:0] scl(int x, bit cl);
    int s;
    s = x * 100 / 1000;
    if (cl) s = s < 0 ? 0 : (s > 100 ? 100 : s);
    return 16'(s);
  endfunction : scl
  task automatic cfg(logic [31:0] c);
    H.wr(8'h00, c, r);
    H.wr(8'h0c, 32'h1, r);
  endtask : cfg
  task automatic cv(logic [2:0] ch, logic [15:0] x, logic o, logic ovr);
    @(posedge sys_clk);
    conv <= '{1'b1, ch, x, o, ovr};
    @(posedge sys_clk);
    conv.valid <= 1'b0;
  endtask : cv
  // ---------------------------------------------------------------
  // Hang guard: the whole run needs about a thousand cycles
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    H.rd(8'h00, d, r);
    `CHK("ctrl", 32'h008, d);
    H.rd(8'h10, d, r);
    `CHK("status", 32'h4, d);
    H.rd(8'hfc, d, r);
    `CHK("rresp", 2'h2, r);
    H.wr(8'hfc, 32'h0, r);
    `CHK("bresp", 2'h2, r);
    H.rd(8'h14, d, r);
    `CHK("irqst", 32'h4, d);
    H.wr(8'h18, 32'h2, r);
    self_test_ok <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("irq masked", 1'b0, irq);
    @(posedge sys_clk);
    supply_present <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("irq", 1'b1, irq);
    H.rd(8'h10, d, r);
    `CHK("status bad", 32'h7, d);
    self_test_ok <= 1'b1;
    supply_present <= 1'b1;
    H.rd(8'h14, d, r);
    `CHK("irqst", 32'h3, d);
    @(negedge sys_clk);
    `CHK("irq clr", 1'b0, irq);
    H.wr(8'h04, 32'h0000_ca90, r);
    `CHK("range out", 32'h0000_ca90, fe_range);
    H.wr(8'h08, 32'h8, r);
    cfg(32'h008);
    H.rd(8'h10, d, r);
    `CHK("commit", 32'h0, d);
    for (int i = 0; i < 12; i++) begin
      m = 2'(i % 3);
      fh = 1'($random(seed));
      cfg({24'h0, 1'b0, m, fh, 4'h8});
      `CHK("detect", m != 2'h2, fe_open_detect_en);
      for (int c = 0; c < 4; c++) begin
        v = 16'($random(seed));
        op = 1'($random(seed));
        ov = 1'($random(seed));
        cv(c[2:0], v, op, ov);
        e = exp_raw(rg[c], c == 3, fh, m, op, v);
        last[c] = e;
        H.rdv(8'(8'h20 + 4 * c), d);
        `CHK("raw", e, d[15:0]);
        H.rd(8'h10, d, r);
        `CHK("oor", ov, d[8 + c]);
        `CHK("burn", op && m != 2'h2, d[16 + c]);
      end
    end
    cfg(32'h002);
    `CHK("count", 4'h2, fe_chan_count);
    cv(3'h2, ~last[2], 1'b1, 1'b1);
    H.rdv(8'h28, d);
    `CHK("hold", last[2], d[15:0]);
    H.rd(8'h10, d, r);
    `CHK("inactive", 2'h0, {d[18], d[10]});
    H.wr(8'h68, 32'h03e8_0000, r);
    H.wr(8'h88, 32'h0064_0000, r);
    for (int k = 0; k < 4; k++) begin
      cfg(k > 1 ? 32'h1c8 : 32'h148);
      cv(3'h2, 16'(sv[k]), 1'b0, 1'b0);
      H.rdv(8'h48, d);
      `CHK("scaled", scl(sv[k], k > 1), d[15:0]);
    end
    tally_and_finish;
  end
endmodule : tvr_readout_tb_top
bind tvr_readout tvr_readout_assertions u_chk (.*);
`default_nettype wire
